/* core/deep_sleep_clock_gate_bank.sv */
// unit clock gating bank with run, sleep and deep-sleep gating registers on axi4-lite
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dsg_cfg.svh"

// Operation
// - gating bit set clocks its unit; clear stops the clock and disables it
// - access to an unclocked unit is answered with a bus fault
// - deep-sleep gating register resets to all zero, every unit unclocked
// - enables come from run, sleep or deep-sleep register by power mode
// - sleep registers only apply when auto clock gating select is set
// - bits 18, 17, 16 are gp counter 2, 1, 0 enables, reset zero
// - bit 12 is the two-wire unit 0 enable, reset zero
// - bit 4 is the sync serial unit 0 enable, reset zero
// - bits 1 and 0 are async serial 1 and 0 enables, reset zero
// - reserved bits read zero and ignore writes; software preserves them
// - bits 26, 25, 24 are comparator 2, 1, 0 enables, reset zero
module deep_sleep_clock_gate_bank #(
  parameter int ADDR_W = 12
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [1:0] i_power_mode,
  input wire logic [9:0] i_unit_access,
  output logic [9:0] o_unit_bus_fault,
  output logic [9:0] o_unit_clk_en,
  output logic [9:0] o_unit_clk,
  output logic o_irq
);

  localparam int N_UNITS = 10;

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 12 and 32");
  end

  // position of unit k inside a gating register
  function automatic int unsigned unit_pos(input int unsigned k);
    unique case (k)
      0: unit_pos = `DSG_POS_ASYNC_SERIAL_0;
      1: unit_pos = `DSG_POS_ASYNC_SERIAL_1;
      2: unit_pos = `DSG_POS_SYNC_SERIAL_0;
      3: unit_pos = `DSG_POS_TWO_WIRE_0;
      4: unit_pos = `DSG_POS_GP_COUNTER_0;
      5: unit_pos = `DSG_POS_GP_COUNTER_1;
      6: unit_pos = `DSG_POS_GP_COUNTER_2;
      7: unit_pos = `DSG_POS_COMPARATOR_0;
      8: unit_pos = `DSG_POS_COMPARATOR_1;
      default: unit_pos = `DSG_POS_COMPARATOR_2;
    endcase
  endfunction

  // word address match, low two bits ignored
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    logic [ADDR_W-1:0] o;
    o = ADDR_W'(off);
    reg_hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
  endfunction

  // byte-strobe merge restricted to writable bits
  function automatic dsg_pkg::word_t wmerge(input dsg_pkg::word_t old, input dsg_pkg::word_t d,
                                            input logic [3:0] s, input dsg_pkg::word_t m);
    dsg_pkg::word_t be;
    be = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & m;
    wmerge = (old & ~be) | (d & be);
  endfunction

  // register file
  dsg_pkg::word_t run_r;
  dsg_pkg::word_t sleep_r;
  dsg_pkg::word_t deep_r;
  dsg_pkg::word_t cfg_r;
  dsg_pkg::word_t stat_r;
  dsg_pkg::word_t mask_r;
  logic [N_UNITS-1:0] unit_en_r;

  // write channel holding
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  dsg_pkg::word_t w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // read channel
  logic rvalid_r;
  logic [1:0] rresp_r;
  dsg_pkg::word_t rdata_r;

  // unit level selection
  logic [N_UNITS-1:0] run_units;
  logic [N_UNITS-1:0] sleep_units;
  logic [N_UNITS-1:0] deep_units;
  logic [N_UNITS-1:0] unit_en_nxt;
  logic [N_UNITS-1:0] fault_vec;

  for (genvar k = 0; k < N_UNITS; k++) begin : g_unit
    assign run_units[k] = run_r[unit_pos(k)];
    assign sleep_units[k] = sleep_r[unit_pos(k)];
    assign deep_units[k] = deep_r[unit_pos(k)];

    unit_clk_gate u_gate (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_en(unit_en_r[k]),
      .o_gclk(o_unit_clk[k])
    );
  end

  wire acg_on = cfg_r[`DSG_CFG_ACG_BIT];
  wire mode_sleep = (i_power_mode == dsg_pkg::PM_SLEEP);
  wire mode_deep = (i_power_mode == dsg_pkg::PM_DEEP);

  assign unit_en_nxt = !acg_on ? run_units :
                       mode_deep ? deep_units :
                       mode_sleep ? sleep_units : run_units;

  unit_fault_guard #(
    .N_UNITS(N_UNITS)
  ) u_guard (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_access(i_unit_access),
    .i_unit_en(unit_en_r),
    .o_fault(fault_vec)
  );

  // write path: address and data may arrive in either order
  wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take = i_s_axi_wvalid && o_s_axi_wready;
  wire wr_fire = aw_full_r && w_full_r && !bvalid_r;
  wire wr_run = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_RUN);
  wire wr_sleep = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_SLEEP);
  wire wr_deep = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_DEEP);
  wire wr_cfg = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_CFG);
  wire wr_stat = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_IRQ_STAT);
  wire wr_mask = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_IRQ_MASK);
  wire wr_state = wr_fire && reg_hit(aw_addr_r, `DSG_OFF_UNIT_STATE);
  wire wr_mapped = wr_run | wr_sleep | wr_deep | wr_cfg | wr_stat | wr_mask | wr_state;

  assign o_s_axi_awready = !aw_full_r && !bvalid_r;
  assign o_s_axi_wready = !w_full_r && !bvalid_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= i_s_axi_wdata;
      w_strb_r <= i_s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `DSG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? `DSG_RESP_OKAY : `DSG_RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_r <= `DSG_RST_GATES;
      sleep_r <= `DSG_RST_GATES;
      deep_r <= `DSG_RST_GATES;
      cfg_r <= `DSG_RST_CFG;
      mask_r <= `DSG_RST_IRQ;
    end else begin
      if (wr_run) run_r <= wmerge(run_r, w_data_r, w_strb_r, `DSG_GATE_MASK);
      if (wr_sleep) sleep_r <= wmerge(sleep_r, w_data_r, w_strb_r, `DSG_GATE_MASK);
      if (wr_deep) deep_r <= wmerge(deep_r, w_data_r, w_strb_r, `DSG_GATE_MASK);
      if (wr_cfg) cfg_r <= wmerge(cfg_r, w_data_r, w_strb_r, `DSG_CFG_MASK);
      if (wr_mask) mask_r <= wmerge(mask_r, w_data_r, w_strb_r, `DSG_IRQ_MASK);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unit_en_r <= '0;
    end else begin
      unit_en_r <= unit_en_nxt;
    end
  end

  // interrupt events: bus fault issued, effective enables changed; set wins over clear
  dsg_pkg::word_t stat_set;
  dsg_pkg::word_t stat_clr;
  assign stat_set = {30'h0000_0000, (unit_en_nxt != unit_en_r), |fault_vec};
  assign stat_clr = wr_stat ? wmerge(32'h0000_0000, w_data_r, w_strb_r, `DSG_IRQ_MASK) :
                    32'h0000_0000;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_r <= `DSG_RST_IRQ;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  assign o_irq = |(stat_r & mask_r);

  // read path
  wire ar_take = i_s_axi_arvalid && o_s_axi_arready;
  wire rd_run = reg_hit(i_s_axi_araddr, `DSG_OFF_RUN);
  wire rd_sleep = reg_hit(i_s_axi_araddr, `DSG_OFF_SLEEP);
  wire rd_deep = reg_hit(i_s_axi_araddr, `DSG_OFF_DEEP);
  wire rd_cfg = reg_hit(i_s_axi_araddr, `DSG_OFF_CFG);
  wire rd_stat = reg_hit(i_s_axi_araddr, `DSG_OFF_IRQ_STAT);
  wire rd_mask = reg_hit(i_s_axi_araddr, `DSG_OFF_IRQ_MASK);
  wire rd_state = reg_hit(i_s_axi_araddr, `DSG_OFF_UNIT_STATE);
  wire rd_mapped = rd_run | rd_sleep | rd_deep | rd_cfg | rd_stat | rd_mask | rd_state;
  dsg_pkg::word_t rd_mux;

  // reserved bits are never stored, so they read zero
  assign rd_mux = rd_run ? run_r :
                  rd_sleep ? sleep_r :
                  rd_deep ? deep_r :
                  rd_cfg ? cfg_r :
                  rd_stat ? stat_r :
                  rd_mask ? mask_r :
                  rd_state ? {22'h00_0000, unit_en_r} : 32'h0000_0000;

  assign o_s_axi_arready = !rvalid_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `DSG_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_mapped ? `DSG_RESP_OKAY : `DSG_RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_unit_clk_en = unit_en_r;
  assign o_unit_bus_fault = fault_vec;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_deep_write;
    wr_deep && (w_strb_r == 4'hF);
  endsequence

  sequence s_deep_mode;
    acg_on && mode_deep;
  endsequence

  sequence s_sleep_mode;
    acg_on && mode_sleep;
  endsequence

  chk_reset_all_off: assert property ($rose(i_resetn) |->
    deep_r == 32'h0000_0000 && unit_en_r == '0)
    else $error("gating state not zero after reset");

  // full-word write stores only unit bits
  chk_deep_write_bits: assert property (s_deep_write |=>
    deep_r == ($past(w_data_r) & `DSG_GATE_MASK)) else $error("deep gating write wrong");

  chk_reserved_zero: assert property (rvalid_r && !$past(rvalid_r) |->
    (rdata_r & ~`DSG_GATE_MASK) == 0 || $past(rd_stat || rd_mask || rd_state || rd_cfg))
    else $error("reserved bits read nonzero");

  chk_deep_mode_src: assert property (s_deep_mode |=>
    unit_en_r == $past(deep_units)) else $error("deep-sleep enables not taken from deep register");

  chk_sleep_mode_src: assert property (s_sleep_mode |=>
    unit_en_r == $past(sleep_units)) else $error("sleep enables not taken from sleep register");

  // without auto gating run settings hold
  chk_no_acg_run: assert property (!acg_on |=>
    unit_en_r == $past(run_units)) else $error("run enables not in force without auto gating");

  // access to unclocked unit faults next cycle
  chk_fault_when_off: assert property ((i_unit_access & ~unit_en_r) != 0 |=>
    o_unit_bus_fault == $past(i_unit_access & ~unit_en_r))
    else $error("missing bus fault for unclocked unit");

  chk_no_fault_on: assert property (##1
    (o_unit_bus_fault & $past(unit_en_r)) == 0) else $error("bus fault on clocked unit");

  // enable output follows a deep write within two cycles
  chk_enable_follow: assert property (s_deep_write ##1 (s_deep_mode [*2]) |->
    unit_en_r == deep_units) else $error("unit enable did not follow register");

  chk_fault_irq_set: assert property (|o_unit_bus_fault |=>
    stat_r[`DSG_IRQ_FAULT_BIT]) else $error("fault status bit not set");

endmodule // deep_sleep_clock_gate_bank

/* core/dsg_cfg.svh */
// register map, field positions, reset values and bus codes of the unit clock gate bank
`ifndef DSG_CFG_SVH
`define DSG_CFG_SVH

// byte offsets
`define DSG_OFF_RUN 12'h104
`define DSG_OFF_SLEEP 12'h114
`define DSG_OFF_DEEP 12'h124
`define DSG_OFF_CFG 12'h060
`define DSG_OFF_IRQ_STAT 12'h130
`define DSG_OFF_IRQ_MASK 12'h134
`define DSG_OFF_UNIT_STATE 12'h138

// reset values
`define DSG_RST_GATES 32'h0000_0000
`define DSG_RST_CFG 32'h0000_0000
`define DSG_RST_IRQ 32'h0000_0000

// writable bits of the three gating registers, all others read as zero
`define DSG_GATE_MASK 32'h0707_1013
// auto_clock_gating_select bit of run_clock_config
`define DSG_CFG_MASK 32'h0000_0001
`define DSG_CFG_ACG_BIT 0

// unit enable positions within a gating register
`define DSG_POS_ASYNC_SERIAL_0 0
`define DSG_POS_ASYNC_SERIAL_1 1
`define DSG_POS_SYNC_SERIAL_0 4
`define DSG_POS_TWO_WIRE_0 12
`define DSG_POS_GP_COUNTER_0 16
`define DSG_POS_GP_COUNTER_1 17
`define DSG_POS_GP_COUNTER_2 18
`define DSG_POS_COMPARATOR_0 24
`define DSG_POS_COMPARATOR_1 25
`define DSG_POS_COMPARATOR_2 26

// interrupt status bits
`define DSG_IRQ_FAULT_BIT 0
`define DSG_IRQ_CHANGE_BIT 1
`define DSG_IRQ_MASK 32'h0000_0003

// axi response codes
`define DSG_RESP_OKAY 2'h0
`define DSG_RESP_SLVERR 2'h2

`endif

/* core/dsg_pkg.sv */
// types shared by the unit clock gate bank
package dsg_pkg;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_SLEEP = 2'b01,
    PM_DEEP = 2'b10
  } power_mode_e;

  typedef logic [31:0] word_t;

endpackage

/* core/unit_clk_gate.sv */
// glitch-free clock gate for one peripheral unit
`timescale 1ns/1ps

module unit_clk_gate (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_en,
  output logic o_gclk
);

  logic en_r;

  // enable only moves while the clock is low, so no pulse is cut short
  always_ff @(negedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_r <= 1'b0;
    end else begin
      en_r <= i_en;
    end
  end

  assign o_gclk = i_core_clk & en_r;

  chk_gate_en_steady: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    en_r == i_en) else $error("gate enable did not follow request");

endmodule // unit_clk_gate

/* core/unit_fault_guard.sv */
// answers peripheral accesses aimed at unclocked units with a bus fault pulse
`timescale 1ns/1ps

module unit_fault_guard #(
  parameter int N_UNITS = 10
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [N_UNITS-1:0] i_access,
  input wire logic [N_UNITS-1:0] i_unit_en,
  output logic [N_UNITS-1:0] o_fault
);

  logic [N_UNITS-1:0] fault_r;
  logic [N_UNITS-1:0] fault_nxt;

  if (N_UNITS < 1) begin : g_chk
    $error("unit_fault_guard needs at least one unit");
  end

  assign fault_nxt = i_access & ~i_unit_en;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign o_fault = fault_r;

endmodule // unit_fault_guard

/* dv/unit_side_model.sv */
// peripheral-side model: issues unit accesses and counts gated clock pulses
`timescale 1ns/1ps

module unit_side_model (
  input wire logic i_core_clk,
  input wire logic [9:0] i_unit_clk,
  input wire logic [9:0] i_fault,
  output logic [9:0] o_access
);
  int pulses [10];

  initial begin
    o_access = 10'h000;
    foreach (pulses[k]) pulses[k] = 0;
  end

  for (genvar g = 0; g < 10; g++) begin : g_cnt
    always @(posedge i_unit_clk[g]) begin
      pulses[g] <= pulses[g] + 1;
    end
  end

  // one-cycle access; the fault answer is sampled while it stands
  task automatic access(input int k, output logic f);
    @(posedge i_core_clk);
    o_access <= 10'h001 << k;
    @(posedge i_core_clk);
    o_access <= 10'h000;
    @(negedge i_core_clk);
    f = i_fault[k];
  endtask
endmodule // unit_side_model

/* dv/deep_sleep_clock_gate_bank_tb.sv */
// self-checking bench for the unit clock gate bank
`timescale 1ns/1ps
`include "dsg_cfg.svh"

module deep_sleep_clock_gate_bank_tb;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [1:0] mode;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [9:0] access, fault, clk_en, uclk;
  int num_errors = 0;
  int cmp_count = 0;
  int pos [10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
  logic [1:0] modes [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [31:0] mode_exp [4] = '{32'h001, 32'h004, 32'h080, 32'h001};

  deep_sleep_clock_gate_bank #(.ADDR_W(12)) i_dut (.i_core_clk(clk), .i_resetn(rstn),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_power_mode(mode),
    .i_unit_access(access), .o_unit_bus_fault(fault), .o_unit_clk_en(clk_en),
    .o_unit_clk(uclk), .o_irq(irq));

  unit_side_model i_model (.i_core_clk(clk), .i_unit_clk(uclk), .i_fault(fault),
    .o_access(access));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout();
    num_errors++;
    $display("CHECK FAILED handshake expected answer seen timeout");
    finish_test();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic aw_go, w_go, b_go;
    logic [1:0] resp;
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) timeout();
    else check("bresp", {30'h0, exp}, {30'h0, resp});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    logic ar_go, r_go;
    logic [31:0] d;
    logic [1:0] resp;
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_go) arvalid <= 1'b0;
      if (r_go) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      timeout();
    end else begin
      check("rdata", exp, d);
      check("rresp", {30'h0, exp_resp}, {30'h0, resp});
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_reset();
    rd(`DSG_OFF_DEEP, 32'h0000_0000, `DSG_RESP_OKAY);
    rd(`DSG_OFF_RUN, 32'h0000_0000, `DSG_RESP_OKAY);
    rd(`DSG_OFF_SLEEP, 32'h0000_0000, `DSG_RESP_OKAY);
    check("clk_en", 32'h0, {22'h0, clk_en});
  endtask

  task automatic t_fields();
    @(posedge clk);
    mode <= dsg_pkg::PM_DEEP;
    wr(`DSG_OFF_CFG, 32'h0000_0001, `DSG_RESP_OKAY);
    wr(`DSG_OFF_DEEP, 32'hFFFF_FFFF, `DSG_RESP_OKAY);
    rd(`DSG_OFF_DEEP, 32'h0707_1013, `DSG_RESP_OKAY);
    for (int k = 0; k < 10; k++) begin
      wr(`DSG_OFF_DEEP, 32'h0000_0001 << pos[k], `DSG_RESP_OKAY);
      settle();
      check("unit_en", 32'h1 << k, {22'h0, clk_en});
    end
    // byte strobe: only byte 2 of an all-ones word lands
    @(posedge clk);
    wstrb <= 4'h4;
    wr(`DSG_OFF_DEEP, 32'hFFFF_FFFF, `DSG_RESP_OKAY);
    rd(`DSG_OFF_DEEP, 32'h0407_0000, `DSG_RESP_OKAY);
    @(posedge clk);
    wstrb <= 4'hF;
  endtask

  task automatic t_modes();
    wr(`DSG_OFF_RUN, 32'h0000_0001, `DSG_RESP_OKAY);
    wr(`DSG_OFF_SLEEP, 32'h0000_0010, `DSG_RESP_OKAY);
    wr(`DSG_OFF_DEEP, 32'h0100_0000, `DSG_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      mode <= modes[k];
      settle();
      check("mode_en", mode_exp[k], {22'h0, clk_en});
    end
    @(posedge clk);
    mode <= dsg_pkg::PM_DEEP;
    wr(`DSG_OFF_CFG, 32'h0000_0000, `DSG_RESP_OKAY);
    settle();
    check("acg_off_en", 32'h001, {22'h0, clk_en});
    wr(`DSG_OFF_CFG, 32'h0000_0001, `DSG_RESP_OKAY);
  endtask

  task automatic t_fault();
    logic f;
    int p4, p5;
    // read, set the needed unit, write back
    rd(`DSG_OFF_DEEP, 32'h0100_0000, `DSG_RESP_OKAY);
    wr(`DSG_OFF_DEEP, 32'h0100_0000 | 32'h0001_0000, `DSG_RESP_OKAY);
    rd(`DSG_OFF_IRQ_STAT, 32'h0000_0002, `DSG_RESP_OKAY);
    rd(`DSG_OFF_UNIT_STATE, 32'h0000_0090, `DSG_RESP_OKAY);
    wr(`DSG_OFF_UNIT_STATE, 32'hFFFF_FFFF, `DSG_RESP_OKAY);
    rd(`DSG_OFF_UNIT_STATE, 32'h0000_0090, `DSG_RESP_OKAY);
    wr(`DSG_OFF_IRQ_MASK, 32'h0000_0001, `DSG_RESP_OKAY);
    wr(`DSG_OFF_IRQ_STAT, 32'h0000_0003, `DSG_RESP_OKAY);
    settle();
    p4 = i_model.pulses[4];
    p5 = i_model.pulses[5];
    repeat (10) @(negedge clk);
    check("pulses_on", 32'h0000_000A, i_model.pulses[4] - p4);
    check("pulses_off", 32'h0, i_model.pulses[5] - p5);
    i_model.access(4, f);
    check("fault_on", 32'h0, {31'h0, f});
    check("irq_idle", 32'h0, {31'h0, irq});
    i_model.access(5, f);
    check("fault_off", 32'h1, {31'h0, f});
    settle();
    check("irq_set", 32'h1, {31'h0, irq});
    rd(`DSG_OFF_IRQ_STAT, 32'h0000_0001, `DSG_RESP_OKAY);
    wr(`DSG_OFF_IRQ_STAT, 32'h0000_0001, `DSG_RESP_OKAY);
    settle();
    check("irq_clr", 32'h0, {31'h0, irq});
    wr(`DSG_OFF_IRQ_MASK, 32'h0000_0000, `DSG_RESP_OKAY);
    i_model.access(5, f);
    settle();
    check("irq_mask", 32'h0, {31'h0, irq});
  endtask

  task automatic t_unmapped();
    wr(12'h200, 32'hFFFF_FFFF, `DSG_RESP_SLVERR);
    rd(12'h200, 32'h0000_0000, `DSG_RESP_SLVERR);
  endtask

  initial begin
    rstn = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    mode = 2'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_fields();
    t_modes();
    t_fault();
    t_unmapped();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`DSG_OFF_DEEP, 32'h0000_0000, `DSG_RESP_OKAY);
    check("clk_en_rst", 32'h0, {22'h0, clk_en});
    finish_test();
  end
endmodule // deep_sleep_clock_gate_bank_tb
